// >>> core/rxcaf_top.sv
`timescale 1ns/1ps
`default_nettype none
// Receive configuration, acceptance filter and DMA start logic
module rxcaf_top
	import rxcaf_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic eeprom_type, // Strap: 1 larger EEPROM
	input wire logic early_mode, // Early receive mode active
	input wire logic frame_start, // Pulse: new frame begins
	input wire logic byte_valid, // Pulse: one byte into FIFO
	input wire logic frame_end, // Pulse: frame complete, desc valid
	input wire rxcaf_frame_t frame, // Frame descriptor
	output rxcaf_verdict_t verdict, // Decision, valid with verdict_valid
	output logic verdict_valid,
	output logic dma_start, // Pulse: begin move to host
	output logic [11:0] rx_burst_bytes, // Rx burst cap, zero unlimited
	output logic [11:0] tx_burst_bytes, // Tx burst cap, zero unlimited
	output logic irq
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [31:0] rx_cfg; // Receive configuration
		logic [31:0] tx_cfg; // Transmit configuration
		logic tx_en; // Transmitter enable bit
		logic eetype; // Captured EEPROM type
		logic [RXCAF_NEV-1:0] stat; // Sticky events
		logic [RXCAF_NEV-1:0] mask; // Event mask
		rxcaf_state_t st; // Packet progress
		logic [11:0] count; // Bytes of current packet
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		rxcaf_verdict_t verdict;
		logic verdict_valid;
		logic dma_start;
		logic [11:0] rx_burst;
		logic [11:0] tx_burst;
		logic irq;
	} rxcaf_regs_t;

	rxcaf_regs_t r; // Current state
	rxcaf_regs_t next_r; // Next state

	logic [11:0] thresh_bytes; // Threshold in bytes, zero whole packet
	logic thresh_rsvd; // Threshold code reserved
	logic [11:0] rx_burst_dec; // Decoded rx burst
	logic rx_burst_rsvd; // Rx burst code reserved
	logic [11:0] tx_burst_dec; // Decoded tx burst

	// ----------------------------------------
	// Code decoders
	// ----------------------------------------
	// Threshold code: 2..6 give 64..1024, 7 whole packet
	rxcaf_size_decode #(.BASE_SHIFT(4)) u_thresh (
		.code(r.rx_cfg[15:13]),
		.reserved_low(1'b1),
		.bytes(thresh_bytes),
		.reserved(thresh_rsvd)
	);

	// Rx burst code 2..6 doubles from 64, 7 unlimited
	rxcaf_size_decode #(.BASE_SHIFT(4)) u_rxb (
		.code(r.rx_cfg[10:8]),
		.reserved_low(1'b1),
		.bytes(rx_burst_dec),
		.reserved(rx_burst_rsvd)
	);

	// Tx burst code 0..6 gives 16..1024, 7 unlimited
	rxcaf_size_decode #(.BASE_SHIFT(4)) u_txb (
		.code(r.tx_cfg[10:8]),
		.reserved_low(1'b0),
		.bytes(tx_burst_dec),
		.reserved()
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic wr; // Write access phase
		logic rd; // Read access phase
		logic [31:0] wbits; // Byte-lane write enables
		logic addr_ok; // Mapped address
		logic dest_ok; // Destination filters passed
		logic err_ok; // Error filter passed
		logic len_ok; // Length filter passed
		logic is_err; // Frame carries an error
		logic crc_short; // CRC above 8 bytes
		logic reached; // Threshold reached
		logic [RXCAF_NEV-1:0] ev; // Events this cycle
		// Every local gets a value first, so no path leaves a latch
		wr = 1'b0;
		rd = 1'b0;
		wbits = 32'h0000_0000;
		addr_ok = 1'b0;
		dest_ok = 1'b0;
		err_ok = 1'b0;
		len_ok = 1'b0;
		is_err = 1'b0;
		crc_short = 1'b0;
		reached = 1'b0;
		ev = '0;
		// Hold everything unless a branch below moves it
		next_r = r;
		wr = psel && penable && pwrite;
		rd = psel && penable && !pwrite;
		for (int i = 0; i < 32; i++) begin
			wbits[i] = pstrb[i / 8];
		end
		addr_ok = (paddr == RXCAF_OFF_RX_CFG) || (paddr == RXCAF_OFF_TX_CFG) ||
			(paddr == RXCAF_OFF_CMD) || (paddr == RXCAF_OFF_IRQ_STAT) ||
			(paddr == RXCAF_OFF_IRQ_MASK);
		ev = '0;
		next_r.eetype = eeprom_type; // Strap sampled every cycle
		next_r.verdict_valid = 1'b0;
		next_r.dma_start = 1'b0;

		// Single-cycle answer: pready high in every access phase
		next_r.pready = psel && !penable;
		next_r.pslverr = psel && !penable && !addr_ok;

		// Register writes
		if (wr && r.pready && !r.pslverr) begin
			unique case (paddr)
				RXCAF_OFF_RX_CFG: begin
					// Only writable bits change, reserved stay zero
					next_r.rx_cfg = (r.rx_cfg & ~(wbits & RXCAF_RX_CFG_WMASK)) |
						(pwdata & wbits & RXCAF_RX_CFG_WMASK);
				end
				RXCAF_OFF_TX_CFG: begin
					// Writes take effect only with transmitter enabled
					if (r.tx_en) begin
						next_r.tx_cfg = (r.tx_cfg & ~(wbits & RXCAF_TX_CFG_WMASK)) |
							(pwdata & wbits & RXCAF_TX_CFG_WMASK);
					end
				end
				RXCAF_OFF_CMD: begin
					if (pstrb[0]) begin
						next_r.tx_en = pwdata[RXCAF_BIT_TXEN];
					end
				end
				RXCAF_OFF_IRQ_MASK: begin
					if (pstrb[0]) begin
						next_r.mask = pwdata[RXCAF_NEV-1:0];
					end
				end
				default: begin
					// Status handled below with write-one-to-clear
				end
			endcase
		end

		// Register reads
		next_r.prdata = 32'h0000_0000;
		if (psel && !penable && !pwrite && addr_ok) begin
			unique case (paddr)
				RXCAF_OFF_RX_CFG: begin
					next_r.prdata = r.rx_cfg & RXCAF_RX_CFG_WMASK;
					next_r.prdata[RXCAF_BIT_EETYPE] = r.eetype;
				end
				RXCAF_OFF_TX_CFG: next_r.prdata = r.tx_cfg;
				RXCAF_OFF_CMD: next_r.prdata[RXCAF_BIT_TXEN] = r.tx_en;
				RXCAF_OFF_IRQ_STAT: next_r.prdata[RXCAF_NEV-1:0] = r.stat;
				RXCAF_OFF_IRQ_MASK: next_r.prdata[RXCAF_NEV-1:0] = r.mask;
				default: next_r.prdata = 32'h0000_0000;
			endcase
		end
		if (rd) begin
			next_r.prdata = r.prdata;
		end

		// ----- Acceptance filter -----
		is_err = frame.crc_err || frame.align_err || frame.collided;
		// Promiscuous, station, multicast, broadcast
		dest_ok = r.rx_cfg[RXCAF_BIT_ALL] ||
			(r.rx_cfg[RXCAF_BIT_STATION] && frame.station) ||
			(r.rx_cfg[RXCAF_BIT_MCAST] && frame.mcast && !frame.bcast) ||
			(r.rx_cfg[RXCAF_BIT_BCAST] && frame.bcast);
		err_ok = !is_err || r.rx_cfg[RXCAF_BIT_ERR];
		// Runts 8..63 bytes need the runt bit
		if (frame.len >= RXCAF_MIN_FRAME) begin
			len_ok = 1'b1;
		end else begin
			len_ok = r.rx_cfg[RXCAF_BIT_RUNT] && (frame.len >= RXCAF_MIN_RUNT);
		end
		// CRC limit: error/runt override, else short-frame bit
		crc_short = r.rx_cfg[RXCAF_BIT_ERR] || r.rx_cfg[RXCAF_BIT_RUNT] ||
			r.rx_cfg[RXCAF_BIT_CRC8];
		if (frame_end) begin
			next_r.verdict_valid = 1'b1;
			next_r.verdict.accept = dest_ok && err_ok && len_ok;
			if (crc_short) begin
				next_r.verdict.crc_check = frame.len > RXCAF_MIN_RUNT;
			end else begin
				next_r.verdict.crc_check = frame.len > RXCAF_MIN_FRAME;
			end
			// With the multi bit set, every packet raises early irq in early mode
			next_r.verdict.early_irq = r.rx_cfg[RXCAF_BIT_MULTI] && early_mode;
			ev[RXCAF_EV_ACCEPT] = dest_ok && err_ok && len_ok;
			ev[RXCAF_EV_REJECT] = !(dest_ok && err_ok && len_ok);
			ev[RXCAF_EV_EARLY] = r.rx_cfg[RXCAF_BIT_MULTI] && early_mode;
		end

		// ----- DMA start tracking -----
		reached = (thresh_bytes != RXCAF_UNLIMITED) && !thresh_rsvd &&
			(12'(r.count + 12'h001) >= thresh_bytes);
		unique case (r.st)
			RXCAF_IDLE: begin
				if (frame_start) begin
					next_r.st = RXCAF_RECV;
					next_r.count = 12'h000;
				end
			end
			RXCAF_RECV: begin
				if (byte_valid && r.count != 12'hfff) begin
					next_r.count = 12'(r.count + 12'h001);
				end
				// Start at threshold or whole packet
				if ((byte_valid && reached) || frame_end) begin
					next_r.dma_start = 1'b1;
					ev[RXCAF_EV_DMA] = 1'b1;
					next_r.st = frame_end ? RXCAF_IDLE : RXCAF_MOVE;
				end
			end
			RXCAF_MOVE: begin
				if (frame_end) begin
					next_r.st = RXCAF_IDLE;
				end
			end
			default: next_r.st = RXCAF_IDLE;
		endcase

		// ----- Interrupts: clear by one, set wins -----
		if (wr && r.pready && !r.pslverr && paddr == RXCAF_OFF_IRQ_STAT && pstrb[0]) begin
			next_r.stat = r.stat & ~pwdata[RXCAF_NEV-1:0];
		end
		next_r.stat = next_r.stat | ev;
		next_r.irq = |(next_r.stat & next_r.mask);

		// ----- Decoded caps -----
		next_r.rx_burst = rx_burst_rsvd ? RXCAF_UNLIMITED : rx_burst_dec;
		next_r.tx_burst = tx_burst_dec;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Reset puts every field at its power-on value
	// Tx cap starts at the code-zero burst so it agrees with tx_cfg
	// Rx cap starts unlimited, as reserved code zero decodes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Constants only in the reset branch
			r <= '0;
			r.rx_cfg <= RXCAF_RX_CFG_RESET; // Short-frame bit zero
			r.tx_cfg <= RXCAF_TX_CFG_RESET;
			r.st <= RXCAF_IDLE;
			r.tx_burst <= RXCAF_TX_BURST_RESET;
		end else begin
			// One copy of the whole state per edge
			r <= next_r;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Each output is a state field, no logic after the flops
	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign verdict = r.verdict;
	assign verdict_valid = r.verdict_valid;
	assign dma_start = r.dma_start;
	assign rx_burst_bytes = r.rx_burst;
	assign tx_burst_bytes = r.tx_burst;
	assign irq = r.irq;

endmodule
`default_nettype wire

// >>> core/rxcaf_pkg.sv
// Behaviour
// - Tx burst code caps burst 16..1024, 7 unlimited
// - Multi early select: every packet raises early irq; the code raises it only while early_mode is high
// - Short-frame CRC set: CRC above 8 bytes
// - Short-frame CRC clear: CRC above 64; resets zero
// - Rx DMA starts at threshold or whole packet
// - Rx threshold codes 2-6 map 64..1024, 7 whole
// - Rx burst codes 2-6 cap 64..1024, 7 unlimited
// - Read-only bit shows attached EEPROM type
// - Accept error bit accepts or rejects errored packets
// - Accept runt takes 8 to 63 byte packets
// - Broadcast bit accepts or rejects broadcasts
// - Multicast bit accepts or rejects multicasts
// - Station match bit accepts own address packets
// - Promiscuous bit accepts any destination address
package rxcaf_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] RXCAF_OFF_RX_CFG = 8'h44; // Receive configuration
	localparam logic [7:0] RXCAF_OFF_TX_CFG = 8'h40; // Transmit configuration
	localparam logic [7:0] RXCAF_OFF_CMD = 8'h48; // Command (tx enable)
	localparam logic [7:0] RXCAF_OFF_IRQ_STAT = 8'h4c; // Sticky event status
	localparam logic [7:0] RXCAF_OFF_IRQ_MASK = 8'h50; // Interrupt mask

	// ----------------------------------------
	// Field layout
	// ----------------------------------------
	localparam int RXCAF_BIT_ALL = 0;
	localparam int RXCAF_BIT_STATION = 1;
	localparam int RXCAF_BIT_MCAST = 2;
	localparam int RXCAF_BIT_BCAST = 3;
	localparam int RXCAF_BIT_RUNT = 4;
	localparam int RXCAF_BIT_ERR = 5;
	localparam int RXCAF_BIT_EETYPE = 6;
	localparam int RXCAF_BIT_CRC8 = 16;
	localparam int RXCAF_BIT_MULTI = 24;
	localparam int RXCAF_BIT_TXEN = 2;
	localparam logic [31:0] RXCAF_RX_CFG_WMASK = 32'h0101_e73f; // Writable bits
	localparam logic [31:0] RXCAF_TX_CFG_WMASK = 32'h0000_0700;
	localparam logic [31:0] RXCAF_RX_CFG_RESET = 32'h0000_0000;
	localparam logic [31:0] RXCAF_TX_CFG_RESET = 32'h0000_0000;
	localparam logic [11:0] RXCAF_TX_BURST_RESET = 12'h010; // Cap of tx code zero

	// ----------------------------------------
	// Sizes in bytes
	// ----------------------------------------
	localparam logic [11:0] RXCAF_MIN_RUNT = 12'h008; // Least runt length
	localparam logic [11:0] RXCAF_MIN_FRAME = 12'h040; // Least normal length
	localparam logic [11:0] RXCAF_UNLIMITED = 12'h000; // Zero marks no cap
	localparam int RXCAF_NEV = 4; // Number of events

	// Event bit numbers
	localparam int RXCAF_EV_ACCEPT = 0;
	localparam int RXCAF_EV_REJECT = 1;
	localparam int RXCAF_EV_EARLY = 2;
	localparam int RXCAF_EV_DMA = 3;

	// Frame descriptor from the receive MAC
	typedef struct packed {
		logic [11:0] len; // Length in bytes
		logic bcast; // Broadcast destination
		logic mcast; // Multicast destination
		logic station; // Own address matched
		logic crc_err; // CRC error
		logic align_err; // Alignment error
		logic collided; // Collided fragment
	} rxcaf_frame_t;

	// Decision presented to the receive path
	typedef struct packed {
		logic accept; // Frame kept
		logic crc_check; // CRC computed for it
		logic early_irq; // Early interrupt raised
	} rxcaf_verdict_t;

	// Packet progress state
	typedef enum logic [1:0] {
		RXCAF_IDLE,
		RXCAF_RECV,
		RXCAF_MOVE
	} rxcaf_state_t;

endpackage

// >>> core/rxcaf_size_decode.sv
`timescale 1ns/1ps
`default_nettype none
// Maps a three-bit size code to a byte count; zero means no limit
module rxcaf_size_decode
	import rxcaf_pkg::*;
#(
	parameter int BASE_SHIFT = 4
) (
	input wire logic [2:0] code,
	input wire logic reserved_low,
	output logic [11:0] bytes,
	output logic reserved
);

	// ----------------------------------------
	// Doubling table
	// ----------------------------------------
	always_comb begin
		reserved = reserved_low && (code < 3'h2);
		if (code == 3'h7) begin
			bytes = RXCAF_UNLIMITED;
		end else begin
			bytes = 12'(12'h001 << (BASE_SHIFT + int'(code)));
		end
	end

endmodule
`default_nettype wire

// >>> sim/rxcaf_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Port checker for the receive filter block
module rxcaf_monitor
	import rxcaf_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic eeprom_type,
	input wire logic early_mode,
	input wire logic frame_start,
	input wire logic byte_valid,
	input wire logic frame_end,
	input wire rxcaf_frame_t frame,
	input wire rxcaf_verdict_t verdict,
	input wire logic verdict_valid,
	input wire logic dma_start,
	input wire logic [11:0] rx_burst_bytes,
	input wire logic [11:0] tx_burst_bytes,
	input wire logic irq
);
	// ----------------
	// Properties
	// ----------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Setup answered in the next cycle
	property p_ready;
		psel && !penable |=> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("pready late");
	property p_tx_burst;
		tx_burst_bytes inside {12'h000, 12'h010, 12'h020, 12'h040,
			12'h080, 12'h100, 12'h200, 12'h400};
	endproperty
	a_tx_burst: assert property (p_tx_burst) else $error("bad tx burst");
	property p_rx_burst;
		rx_burst_bytes inside {12'h000, 12'h040, 12'h080, 12'h100, 12'h200, 12'h400};
	endproperty
	a_rx_burst: assert property (p_rx_burst) else $error("bad rx burst");
	// Reserved bits of the config read zero
	property p_rsv;
		pready && !pwrite && paddr == RXCAF_OFF_RX_CFG |->
			(prdata & ~(RXCAF_RX_CFG_WMASK | 32'h0000_0040)) == 32'h0000_0000;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bit set");
	property p_crc_min;
		verdict_valid && $past(frame.len) <= RXCAF_MIN_RUNT |-> !verdict.crc_check;
	endproperty
	a_crc_min: assert property (p_crc_min) else $error("crc on tiny frame");
	property p_runt_min;
		verdict_valid && $past(frame.len) < RXCAF_MIN_RUNT |-> !verdict.accept;
	endproperty
	a_runt_min: assert property (p_runt_min) else $error("tiny frame kept");
	property p_early;
		verdict_valid && verdict.early_irq |-> $past(early_mode);
	endproperty
	a_early: assert property (p_early) else $error("early irq off mode");
	property p_dma;
		dma_start |-> $past(byte_valid || frame_end);
	endproperty
	a_dma: assert property (p_dma) else $error("dma start uncaused");
	// Main scenarios
	c_accept: cover property (verdict_valid && verdict.accept);
	c_dma: cover property (dma_start);
	c_irq: cover property (irq);
endmodule
`default_nettype wire

// >>> sim/rxcaf_src.sv
`timescale 1ns/1ps
`default_nettype none
// Receive MAC model feeding frames, one byte a cycle
module rxcaf_src
	import rxcaf_pkg::*;
(
	input wire logic pclk,
	output logic frame_start,
	output logic byte_valid,
	output logic frame_end,
	output rxcaf_frame_t frame
);
	initial begin
		frame_start = 1'b0;
		byte_valid = 1'b0;
		frame_end = 1'b0;
		frame = '0;
	end
	// Descriptor valid only at frame end, inverted elsewhere
	task automatic send(input rxcaf_frame_t f);
		@(posedge pclk) frame_start <= 1'b1;
		frame <= ~f;
		for (int i = 0; i < f.len; i++) begin
			@(posedge pclk) frame_start <= 1'b0;
			byte_valid <= 1'b1;
		end
		@(posedge pclk) frame_start <= 1'b0;
		byte_valid <= 1'b0;
		frame_end <= 1'b1;
		frame <= f;
		@(posedge pclk) frame_end <= 1'b0;
		frame <= ~f;
	endtask
endmodule
`default_nettype wire

// >>> sim/rxcaf_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rxcaf_top_tb
	import rxcaf_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, eeprom_type, early_mode, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [3:0] pstrb;
	logic pready, pslverr, frame_start, byte_valid, frame_end, verdict_valid, dma_start, irq;
	rxcaf_frame_t frame;
	rxcaf_verdict_t verdict, vcap;
	logic [11:0] rx_burst_bytes, tx_burst_bytes, nb, dma_at;
	int failures = 0, total_checks = 0, vseen = 0;
	logic [31:0] cf [20] = '{8, 4, 4, 2, 0, 1, 1, 'h21, 'h21, 'h21, 'h11, 'h11, 1, 'h10001,
		'h10001, 1, 'h11, 'h21, 'h1000001, 'h10};
	rxcaf_frame_t fr [20] = '{{12'h040, 6'h20}, {12'h040, 6'h20}, {12'h040, 6'h10},
		{12'h040, 6'h08}, {12'h040, 6'h08}, {12'h040, 6'h00}, {12'h040, 6'h04},
		{12'h040, 6'h04}, {12'h040, 6'h02}, {12'h040, 6'h01}, {12'h008, 6'h00},
		{12'h007, 6'h00}, {12'h03f, 6'h00}, {12'h009, 6'h00}, {12'h008, 6'h00},
		{12'h041, 6'h00}, {12'h014, 6'h00}, {12'h020, 6'h00}, {12'h040, 6'h00},
		{12'h040, 6'h00}};
	rxcaf_top i_rxcaf_top (.*);
	rxcaf_src i_rxcaf_src (.*);
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// Capture verdicts and the byte count at dma start
	always @(posedge pclk) begin
		if (verdict_valid === 1'b1) begin
			vcap <= verdict;
			vseen <= vseen + 1;
		end
		nb <= frame_start ? 12'h000 : nb + byte_valid;
		if (dma_start === 1'b1) dma_at <= nb;
	end
	task automatic chk(string n, logic [31:0] x, logic [31:0] g);
		total_checks++;
		if (g !== x) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] q,
		output logic s);
		@(posedge pclk) psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		s = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		apb(1'b1, a, d, r, e);
	endtask
	task automatic settle();
		repeat (2) @(posedge pclk);
		#1;
	endtask
	function automatic logic [1:0] exp_v(logic [31:0] c, rxcaf_frame_t f);
		logic d, ok;
		d = c[0] | (f.bcast & c[3]) | (f.mcast & ~f.bcast & c[2]) | (f.station & c[1]);
		ok = ~(f.crc_err | f.align_err | f.collided) | c[5];
		exp_v[1] = d & ok & (f.len >= 12'h040 | (c[4] & f.len >= 12'h008));
		exp_v[0] = (c[16] | c[5] | c[4]) ? f.len > 12'h008 : f.len > 12'h040;
	endfunction
	// Reset values, read-only strap, reserved bits, burst codes
	task automatic t_regs();
		apb(1'b0, RXCAF_OFF_RX_CFG, 0, r, e);
		chk("rx cfg reset", 32'h0000_0000, r);
		chk("tx burst reset", 32'h0000_0010, tx_burst_bytes);
		wr(RXCAF_OFF_RX_CFG, 32'hffff_ffff);
		eeprom_type <= 1'b1;
		settle();
		apb(1'b0, RXCAF_OFF_RX_CFG, 0, r, e);
		chk("rx cfg", RXCAF_RX_CFG_WMASK | 32'h0000_0040, r);
		// Lane zero only: upper bytes keep their ones
		pstrb <= 4'h1;
		wr(RXCAF_OFF_RX_CFG, 32'h0000_0000);
		pstrb <= 4'hf;
		apb(1'b0, RXCAF_OFF_RX_CFG, 32'h0000_0000, r, e);
		chk("rx cfg lane", (RXCAF_RX_CFG_WMASK & 32'hffff_ff00) | 32'h0000_0040, r);
		wr(RXCAF_OFF_TX_CFG, 32'h0000_0300);
		settle();
		chk("tx locked", 32'h0000_0010, tx_burst_bytes);
		wr(RXCAF_OFF_CMD, 32'h0000_0004); // Enable transmitter first
		for (int c = 0; c < 8; c++) begin
			wr(RXCAF_OFF_TX_CFG, c << 8);
			wr(RXCAF_OFF_RX_CFG, c << 8);
			settle();
			chk("tx burst", (c == 7) ? 0 : 16 << c, tx_burst_bytes);
			chk("rx burst", (c < 2 || c == 7) ? 0 : 16 << c, rx_burst_bytes);
		end
		$display("t_regs done");
	endtask
	// Acceptance and CRC decisions over a table of frames
	task automatic t_filter();
		logic [1:0] xv; // Expected accept and crc
		for (int i = 0; i < 20; i++) begin
			wr(RXCAF_OFF_RX_CFG, cf[i]);
			i_rxcaf_src.send(fr[i]);
			settle();
			xv = exp_v(cf[i], fr[i]);
			chk("accept", xv[1], vcap.accept);
			chk("crc check", xv[0], vcap.crc_check);
			chk("early irq", cf[i][RXCAF_BIT_MULTI], vcap.early_irq);
			chk("verdicts", i + 1, vseen);
		end
		$display("t_filter done");
	endtask
	// Dma start point for every threshold code
	task automatic t_thresh();
		int xd; // Expected byte count at dma start
		for (int c = 0; c < 8; c++) begin
			wr(RXCAF_OFF_RX_CFG, 1 | (c << 13));
			i_rxcaf_src.send({12'h12c, 6'h00});
			settle();
			xd = (c > 1 && c < 7 && (16 << c) < 300) ? 16 << c : 300;
			chk("dma at", xd, dma_at);
		end
		$display("t_thresh done");
	endtask
	// Sticky status, mask, clear and unmapped access
	task automatic t_irq();
		// Earlier tests raised every event kind
		apb(1'b0, RXCAF_OFF_IRQ_STAT, 32'h0000_0000, r, e);
		chk("status sticky", 32'h0000_000f, r);
		early_mode <= 1'b0;
		wr(RXCAF_OFF_IRQ_MASK, 32'h0000_0000);
		wr(RXCAF_OFF_IRQ_STAT, 32'h0000_000f);
		wr(RXCAF_OFF_RX_CFG, 32'h0100_0001);
		i_rxcaf_src.send({12'h040, 6'h00});
		settle();
		chk("early off mode", 32'h0000_0000, vcap.early_irq);
		apb(1'b0, RXCAF_OFF_IRQ_STAT, 0, r, e);
		chk("status", 32'h9, r);
		chk("irq masked", 0, irq);
		wr(RXCAF_OFF_IRQ_MASK, 1);
		settle();
		chk("irq", 1, irq);
		wr(RXCAF_OFF_IRQ_STAT, 1);
		settle();
		chk("irq cleared", 0, irq);
		apb(1'b0, 8'h10, 0, r, e);
		chk("slverr", 1, e);
		chk("unmapped", 0, r);
		$display("t_irq done");
	endtask
	task automatic results();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		#2000000;
		failures++;
		results();
	end
	initial begin
		{psel, penable, pwrite, eeprom_type, presetn} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hf;
		early_mode = 1'b1;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_filter();
		t_thresh();
		t_irq();
		results();
	end
endmodule
bind rxcaf_top rxcaf_monitor i_rxcaf_monitor (.*);
`default_nettype wire
